//--- src/pmx_defs.svh
`ifndef PMX_DEFS_SVH
`define PMX_DEFS_SVH

// line counts per port
`define PMX_NUM_A        23
`define PMX_NUM_B        28
`define PMX_LINE_W       6

// fixed line positions, port B lines follow port A lines
`define PMX_TCK_LINE     0
`define PMX_TMS_LINE     1
`define PMX_TDI_LINE     2
`define PMX_TDO_LINE     3
`define PMX_RC_LINE      20
`define PMX_USB_DM_LINE  36
`define PMX_USB_DP_LINE  37

// per-line masks and reset values, bit n is line n
`define PMX_TWI_MASK     51'h0_0000_1822_00A0
`define PMX_RC_MASK      51'h0_0000_0010_0000
`define PMX_PULL_RST     51'h0_0000_0000_0001
`define PMX_GPIO_RST     (~(`PMX_TWI_MASK | `PMX_RC_MASK))
`define PMX_ADC_MASK     51'h0_0000_0001_C000

`endif

//--- src/pmx_pkg.sv
package pmx_pkg;

	// peripheral function selector of one line
	typedef enum logic [2:0] {
		PMX_FN_A = 3'h0,
		PMX_FN_B = 3'h1,
		PMX_FN_C = 3'h2,
		PMX_FN_D = 3'h3,
		PMX_FN_E = 3'h4,
		PMX_FN_F = 3'h5,
		PMX_FN_G = 3'h6,
		PMX_FN_H = 3'h7
	} pmx_func_t;

	// functions with a fixed meaning in the pad logic
	localparam pmx_func_t PMX_FN_TWI = PMX_FN_A;
	localparam pmx_func_t PMX_FN_RC  = PMX_FN_F;
	localparam pmx_func_t PMX_FN_USB = PMX_FN_A;

	// one line's configuration as written by software
	typedef struct packed {
		logic      gpio_en;
		logic      oe;
		logic      out;
		logic      pull;
		pmx_func_t func;
	} pmx_line_cfg_t;

endpackage : pmx_pkg

//--- src/pmx_pin_mux.sv
`timescale 1ns/1ps
`include "pmx_defs.svh"

// How it works
// - test port enabled only if test clock is low at external reset release.
// - while test port enabled, pull-ups on test clock, mode select, data in.
// - test clock pull-up always on during reset.
// - test data out driven as output, never pulled up.
// - test port disabled: its pins serve as GPIO or peripheral lines.
// - after reset two-wire pins select their two-wire function.
// - two-wire function: open-drain out, spike-filtered in; else plain line.
// - each line has its own programmable pull-up enable.
// - reset: lines inputs except port_a_line_twenty, pull-ups off except port_a_line_zero.
// - after reset port_a_line_twenty selects function F, the slow RC clock.
// - slow RC clock on port_a_line_twenty from power-up, also during reset.
// - clock output stops on non-F function, GPIO, or force bit written zero.
// - once stopped the clock output restarts only at power-on reset.
// - alternate crystal output does not stop the clock; software must.
// - analog input blocked while the line's driver drives high.
// - USB pads follow USB when selected, else plain lines.
module pmx_pin_mux #(
	parameter int NA = `PMX_NUM_A,
	parameter int NB = `PMX_NUM_B
) (
	// clock and power-on reset
	input  wire logic                  i_clk,
	input  wire logic                  i_srst,
	// external reset pin, low while held
	input  wire logic                  i_rst_pin_n,
	// pad inputs and peripheral drive
	input  wire logic [NA+NB-1:0]      i_pad_in,
	input  wire logic [NA+NB-1:0]      i_per_out,
	input  wire logic [NA+NB-1:0]      i_per_oe,
	input  wire logic                  i_tdo,
	input  wire logic                  i_slow_rc_oscillator,
	// line configuration write
	input  wire logic                  i_cfg_we,
	input  wire logic [`PMX_LINE_W-1:0] i_cfg_line,
	input  wire pmx_pkg::pmx_line_cfg_t i_cfg,
	// force bit of the peripheral power control register
	input  wire logic                  i_force_rc_output_bit_we,
	input  wire logic                  i_force_rc_output_bit,
	// analog input requests
	input  wire logic [NA+NB-1:0]      i_adc_req,
	// pad controls
	output logic      [NA+NB-1:0]      o_pad_out,
	output logic      [NA+NB-1:0]      o_pad_oe,
	output logic      [NA+NB-1:0]      o_pad_pull,
	output logic      [NA+NB-1:0]      o_line_in,
	output logic      [NA+NB-1:0]      o_adc_en,
	// test port and status
	output logic                       o_jtag_en,
	output logic                       o_tck,
	output logic                       o_tms,
	output logic                       o_tdi,
	output logic                       o_slow_rc_clock_output_on,
	output logic                       o_usb_sel
);

	localparam int N   = NA + NB;
	localparam int TCK = `PMX_TCK_LINE;
	localparam int TMS = `PMX_TMS_LINE;
	localparam int TDI = `PMX_TDI_LINE;
	localparam int TDO = `PMX_TDO_LINE;
	localparam int PORT_A_LINE_TWENTY = `PMX_RC_LINE;
	localparam int UDM = `PMX_USB_DM_LINE;
	localparam int UDP = `PMX_USB_DP_LINE;
	localparam logic [N-1:0] TWI_M  = N'(`PMX_TWI_MASK);
	localparam logic [N-1:0] ADC_M  = N'(`PMX_ADC_MASK);
	localparam logic [N-1:0] GPIO_R = N'(`PMX_GPIO_RST);
	localparam logic [N-1:0] PULL_R = N'(`PMX_PULL_RST);

	// whole state of the block
	typedef struct packed {
		logic [N-1:0]      gpio_en;
		logic [N-1:0]      oe;
		logic [N-1:0]      out;
		logic [N-1:0]      pull;
		logic [N-1:0][2:0] func;
		logic [N-1:0]      smp0;
		logic [N-1:0]      smp1;
		logic [N-1:0]      filt;
		logic [N-1:0]      pad_out;
		logic [N-1:0]      pad_oe;
		logic [N-1:0]      pad_pull;
		logic [N-1:0]      line_in;
		logic [N-1:0]      adc_en;
		logic              ext_rst_q;
		logic              jtag_en;
		logic              rc_on;
		logic              usb_sel;
		logic              tck;
		logic              tms;
		logic              tdi;
	} pmx_state_t;

	pmx_state_t st_reg;
	pmx_state_t st_next;

	// lines whose two-wire function is selected; shared by the pad logic and its check
	function automatic logic [N-1:0] twi_lines(input pmx_state_t s);
		logic [N-1:0] v;
		v = '0;
		for (int i = 0; i < N; i++) begin
			v[i] = TWI_M[i] && !s.gpio_en[i] &&
				(s.func[i] == pmx_pkg::PMX_FN_TWI);
		end
		return v;
	endfunction : twi_lines

	// two-wire selection of the stored configuration
	logic [N-1:0] twi_now;
	assign twi_now = twi_lines(st_reg);

	// next state; reset is folded in here so the rc clock can pass during it
	always_comb begin
		logic twi;
		logic jt;
		twi = 1'b0;
		jt  = 1'b0;
		st_next = st_reg;
		// software writes one line's whole configuration
		if (i_cfg_we && (32'(i_cfg_line) < N)) begin
			st_next.gpio_en[i_cfg_line] = i_cfg.gpio_en;
			st_next.oe[i_cfg_line]      = i_cfg.oe;
			st_next.out[i_cfg_line]     = i_cfg.out;
			st_next.pull[i_cfg_line]    = i_cfg.pull;
			st_next.func[i_cfg_line]    = i_cfg.func;
		end
		// test port decision is taken only at the release edge
		st_next.ext_rst_q = i_rst_pin_n;
		if (i_rst_pin_n && !st_reg.ext_rst_q) begin
			st_next.jtag_en = !i_pad_in[TCK];
		end
		// sticky stop; alt crystal enable is deliberately not a cause
		if (st_reg.gpio_en[PORT_A_LINE_TWENTY] ||
			(st_reg.func[PORT_A_LINE_TWENTY] != pmx_pkg::PMX_FN_RC) ||
			(i_force_rc_output_bit_we && !i_force_rc_output_bit)) begin
			st_next.rc_on = 1'b0;
		end
		// per-line pad control and input path
		for (int i = 0; i < N; i++) begin
			twi = twi_now[i];
			jt = st_reg.jtag_en && (i <= TDO);
			st_next.smp0[i] = i_pad_in[i];
			st_next.smp1[i] = st_reg.smp0[i];
			// a glitch must hold three samples to pass
			if (!twi) begin
				st_next.filt[i] = i_pad_in[i];
			end else if ((st_reg.smp0[i] == i_pad_in[i]) &&
				(st_reg.smp1[i] == st_reg.smp0[i])) begin
				st_next.filt[i] = i_pad_in[i];
			end
			st_next.line_in[i]  = st_next.filt[i];
			st_next.pad_pull[i] = st_reg.pull[i];
			if (jt) begin
				st_next.pad_oe[i]   = (i == TDO);
				st_next.pad_out[i]  = (i == TDO) && i_tdo;
				st_next.pad_pull[i] = (i != TDO);
			end else if (st_reg.gpio_en[i]) begin
				st_next.pad_oe[i]  = st_reg.oe[i];
				st_next.pad_out[i] = st_reg.out[i];
			end else if (twi) begin
				// open drain: only ever pulls low
				st_next.pad_oe[i]  = !i_per_out[i];
				st_next.pad_out[i] = 1'b0;
			end else if ((i == PORT_A_LINE_TWENTY) && st_reg.rc_on &&
				(st_reg.func[i] == pmx_pkg::PMX_FN_RC)) begin
				st_next.pad_oe[i]  = 1'b1;
				st_next.pad_out[i] = i_slow_rc_oscillator;
			end else begin
				st_next.pad_oe[i]  = i_per_oe[i];
				st_next.pad_out[i] = i_per_out[i];
			end
			// analog use only while the driver is not pulling high
			st_next.adc_en[i] = i_adc_req[i] && ADC_M[i] &&
				!(st_next.pad_oe[i] && st_next.pad_out[i]);
		end
		// test port inputs reach the core only while it is enabled
		st_next.tck = st_reg.jtag_en && i_pad_in[TCK];
		st_next.tms = st_reg.jtag_en && i_pad_in[TMS];
		st_next.tdi = st_reg.jtag_en && i_pad_in[TDI];
		// both pads must agree before the transceiver takes over
		st_next.usb_sel = !st_reg.gpio_en[UDM] && !st_reg.gpio_en[UDP] &&
			(st_reg.func[UDM] == pmx_pkg::PMX_FN_USB) &&
			(st_reg.func[UDP] == pmx_pkg::PMX_FN_USB);
		// external reset keeps the test clock pulled up
		if (!i_rst_pin_n) begin
			st_next.pad_pull[TCK] = 1'b1;
		end
		// power-on reset: the only clear of the sticky stop flag
		if (i_srst) begin
			st_next          = '0;
			st_next.rc_on    = 1'b1;
			st_next.gpio_en  = GPIO_R;
			st_next.pull     = PULL_R;
			st_next.pad_pull = PULL_R;
			st_next.func[PORT_A_LINE_TWENTY] = pmx_pkg::PMX_FN_RC;
			st_next.pad_oe[PORT_A_LINE_TWENTY]  = 1'b1;
			st_next.pad_out[PORT_A_LINE_TWENTY] = i_slow_rc_oscillator;
		end
	end

	// state register, reset handled in the next-state logic
	always_ff @(posedge i_clk) begin
		st_reg <= st_next;
	end

	// outputs straight from the state register
	assign o_pad_out  = st_reg.pad_out;
	assign o_pad_oe   = st_reg.pad_oe;
	assign o_pad_pull = st_reg.pad_pull;
	assign o_line_in  = st_reg.line_in;
	assign o_adc_en   = st_reg.adc_en;
	assign o_jtag_en  = st_reg.jtag_en;
	assign o_tck      = st_reg.tck;
	assign o_tms      = st_reg.tms;
	assign o_tdi      = st_reg.tdi;
	assign o_usb_sel  = st_reg.usb_sel;
	assign o_slow_rc_clock_output_on = st_reg.rc_on;

	// release of the external reset pin
	sequence s_release;
		!i_rst_pin_n ##1 i_rst_pin_n;
	endsequence

	// a pull-up write to a plain line, then a quiet cycle
	sequence s_pull_write;
		i_cfg_we && i_cfg.gpio_en && (i_cfg_line > 6'(TDO)) &&
			(32'(i_cfg_line) < N) ##1 !i_cfg_we;
	endsequence

	// test port follows the test clock level at release
	property p_jtag_sample;
		@(posedge i_clk) disable iff (i_srst)
		s_release |=> (o_jtag_en == !$past(i_pad_in[TCK]));
	endproperty
	a_jtag_sample: assert property (p_jtag_sample)
		else $error("test port enable does not match sampled clock");

	// without a release the decision holds; end of power-on reset counts as one
	property p_jtag_hold;
		@(posedge i_clk) disable iff (i_srst)
		!(i_rst_pin_n && (!$past(i_rst_pin_n) || $past(i_srst))) |=> $stable(o_jtag_en);
	endproperty
	a_jtag_hold: assert property (p_jtag_hold)
		else $error("test port enable changed outside a release");

	// enabled test port pulls its inputs up
	property p_jtag_pull;
		@(posedge i_clk) disable iff (i_srst)
		o_jtag_en && $past(o_jtag_en) |->
			o_pad_pull[TCK] && o_pad_pull[TMS] && o_pad_pull[TDI];
	endproperty
	a_jtag_pull: assert property (p_jtag_pull)
		else $error("test port input lacks pull-up");

	// external reset keeps the clock pad pulled up
	property p_tck_rst_pull;
		@(posedge i_clk) disable iff (i_srst)
		!i_rst_pin_n |=> o_pad_pull[TCK];
	endproperty
	a_tck_rst_pull: assert property (p_tck_rst_pull)
		else $error("test clock pull-up off during reset");

	// test data out drives with no pull-up
	property p_tdo_drive;
		@(posedge i_clk) disable iff (i_srst)
		o_jtag_en && $past(o_jtag_en) |->
			o_pad_oe[TDO] && !o_pad_pull[TDO] &&
			(o_pad_out[TDO] == $past(i_tdo));
	endproperty
	a_tdo_drive: assert property (p_tdo_drive)
		else $error("test data out not driven as output");

	// disabled test port passes nothing to the core
	property p_tap_gate;
		@(posedge i_clk) disable iff (i_srst)
		!$past(o_jtag_en) |-> !o_tck && !o_tms && !o_tdi;
	endproperty
	a_tap_gate: assert property (p_tap_gate)
		else $error("test inputs pass while port disabled");

	// two-wire line only ever pulls low
	property p_twi_od;
		@(posedge i_clk) disable iff (i_srst)
		(o_pad_oe & o_pad_out & $past(twi_now)) == '0;
	endproperty
	a_twi_od: assert property (p_twi_od)
		else $error("two-wire line driven high");

	// defaults right after power-on reset
	property p_por_defaults;
		@(posedge i_clk)
		$past(i_srst) && !i_srst |->
			(o_pad_pull == PULL_R) && (o_pad_oe == N'(`PMX_RC_MASK)) &&
			!o_jtag_en && o_slow_rc_clock_output_on && !o_usb_sel;
	endproperty
	a_por_defaults: assert property (p_por_defaults)
		else $error("reset defaults wrong");

	// a written pull-up reaches the pad two cycles later
	property p_pull_write;
		@(posedge i_clk) disable iff (i_srst)
		s_pull_write |=> (o_pad_pull[$past(i_cfg_line, 2)] ==
			$past(i_cfg.pull, 2));
	endproperty
	a_pull_write: assert property (p_pull_write)
		else $error("pull-up write not applied");

	// clock passes to the pad while the output is on
	property p_rc_pass;
		@(posedge i_clk) disable iff (i_srst)
		$past(o_slow_rc_clock_output_on) && !$past(i_srst) &&
			!$past(st_reg.gpio_en[PORT_A_LINE_TWENTY]) &&
			($past(st_reg.func[PORT_A_LINE_TWENTY]) == pmx_pkg::PMX_FN_RC) |->
			o_pad_oe[PORT_A_LINE_TWENTY] &&
			(o_pad_out[PORT_A_LINE_TWENTY] == $past(i_slow_rc_oscillator));
	endproperty
	a_rc_pass: assert property (p_rc_pass)
		else $error("slow clock not on its pad");

	// force bit written zero stops the output next cycle
	property p_rc_force_off;
		@(posedge i_clk) disable iff (i_srst)
		i_force_rc_output_bit_we && !i_force_rc_output_bit |=>
			!o_slow_rc_clock_output_on;
	endproperty
	a_rc_force_off: assert property (p_rc_force_off)
		else $error("force bit zero did not stop clock");

	// stopped output stays stopped until power-on reset
	property p_rc_sticky;
		@(posedge i_clk) disable iff (i_srst)
		!o_slow_rc_clock_output_on |=> !o_slow_rc_clock_output_on;
	endproperty
	a_rc_sticky: assert property (p_rc_sticky)
		else $error("slow clock output restarted");

	// no analog use while the pad drives high
	property p_adc_block;
		@(posedge i_clk) disable iff (i_srst)
		(o_adc_en & o_pad_oe & o_pad_out) == '0;
	endproperty
	a_adc_block: assert property (p_adc_block)
		else $error("analog input enabled on a high-driven pad");

endmodule : pmx_pin_mux

//--- tb/pmx_pin_mux_tb.sv
`timescale 1ns/1ps
`include "pmx_defs.svh"

module pmx_pin_mux_tb;
	localparam int N = `PMX_NUM_A + `PMX_NUM_B;
	// design inputs and outputs
	logic                   i_clk, i_srst, i_rst_pin_n, i_tdo, i_slow_rc_oscillator;
	logic                   i_cfg_we, i_force_rc_output_bit_we, i_force_rc_output_bit;
	logic [5:0]             i_cfg_line;
	pmx_pkg::pmx_line_cfg_t i_cfg;
	logic [N-1:0]           i_pad_in, i_per_out, i_per_oe, i_adc_req;
	logic [N-1:0]           o_pad_out, o_pad_oe, o_pad_pull, o_line_in, o_adc_en;
	logic                   o_jtag_en, o_tck, o_tms, o_tdi, o_slow_rc_clock_output_on;
	logic                   o_usb_sel;
	// bench state: previous-cycle inputs form the model of the registered outputs
	logic [N-1:0]           p_per, p_pad, exp_pull;
	logic                   p_osc, live, rc;
	logic [31:0]            rnd;
	int                     mismatches, n_checks;

	pmx_pin_mux i_pmx_pin_mux (.i_clk(i_clk), .i_srst(i_srst), .i_rst_pin_n(i_rst_pin_n),
		.i_pad_in(i_pad_in), .i_per_out(i_per_out), .i_per_oe(i_per_oe), .i_tdo(i_tdo),
		.i_slow_rc_oscillator(i_slow_rc_oscillator), .i_cfg_we(i_cfg_we),
		.i_cfg_line(i_cfg_line), .i_cfg(i_cfg),
		.i_force_rc_output_bit_we(i_force_rc_output_bit_we),
		.i_force_rc_output_bit(i_force_rc_output_bit), .i_adc_req(i_adc_req),
		.o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe), .o_pad_pull(o_pad_pull),
		.o_line_in(o_line_in), .o_adc_en(o_adc_en), .o_jtag_en(o_jtag_en), .o_tck(o_tck),
		.o_tms(o_tms), .o_tdi(o_tdi), .o_slow_rc_clock_output_on(o_slow_rc_clock_output_on),
		.o_usb_sel(o_usb_sel));

	// free-running 100 MHz clock
	always #5 i_clk = ~i_clk;

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : xs

	task automatic close_out();
		if (mismatches == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out

	task automatic chk_vec(input logic [63:0] got, input logic [63:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : chk_vec

	task automatic chk_bit(input logic got, input logic exp, input string m);
		chk_vec({63'h0, got}, {63'h0, exp}, m);
	endtask : chk_bit

	// one cycle: inputs change 1 ns after the edge, registered outputs checked then
	task automatic step(input int n);
		for (int k = 0; k < n; k++) begin
			p_osc = i_slow_rc_oscillator;
			p_per = i_per_out;
			p_pad = i_pad_in;
			@(posedge i_clk);
			#1;
			rnd = xs(rnd);
			i_slow_rc_oscillator = ~i_slow_rc_oscillator;
			i_per_out = {rnd, rnd[18:0]};
			i_pad_in[13:8] = rnd[5:0];
			if (rc) chk_bit(o_pad_out[20], p_osc, "slow clock on pad");
			if (live) begin
				chk_bit(o_line_in[10], p_pad[10], "plain line input");
				chk_bit(o_pad_oe[27], ~p_per[27], "two-wire drive");
				chk_bit(o_pad_out[27], 1'b0, "two-wire level");
			end
		end
	endtask : step

	task automatic wr(input int ln, input logic g, input logic o, input logic d,
		input logic p, input pmx_pkg::pmx_func_t f);
		i_cfg_we = 1'b1;
		i_cfg_line = ln[5:0];
		i_cfg = '{gpio_en: g, oe: o, out: d, pull: p, func: f};
		step(1);
		i_cfg_we = 1'b0;
		step(2);
	endtask : wr

	task automatic force_bit(input logic v);
		i_force_rc_output_bit_we = 1'b1;
		i_force_rc_output_bit = v;
		step(1);
		i_force_rc_output_bit_we = 1'b0;
		step(2);
	endtask : force_bit

	// power-on reset; external reset pin stays high so release sees pad 0
	task automatic do_reset();
		live = 1'b0;
		rc = 1'b0;
		i_srst = 1'b1;
		step(1);
		rc = 1'b1;
		repeat (9) begin
			step(1);
			chk_vec(64'(o_pad_pull), 64'(`PMX_PULL_RST), "reset pulls");
			chk_vec(64'(o_pad_oe), 64'(`PMX_RC_MASK), "reset drive");
			chk_bit(o_slow_rc_clock_output_on, 1'b1, "clock on in reset");
		end
		i_srst = 1'b0;
		step(2);
		live = 1'b1;
	endtask : do_reset

	initial begin
		i_clk = 0; i_srst = 1; i_rst_pin_n = 1; i_tdo = 0; i_slow_rc_oscillator = 0;
		i_cfg_we = 0; i_cfg_line = '0; i_cfg = '0; i_force_rc_output_bit_we = 0;
		i_force_rc_output_bit = 1; i_pad_in = '0; i_per_out = '0; i_per_oe = '0;
		i_adc_req = '0; mismatches = 0; n_checks = 0; rnd = 32'h0000_0039;
		i_pad_in[0] = 1'b1;
		do_reset();
		chk_bit(o_jtag_en, 1'b0, "test port with clock high");
		chk_bit(o_usb_sel, 1'b0, "usb default");
		// test port: clock low at external reset release
		// the reset pin is driven as a plain reset, once more below while the test port is enabled
		i_rst_pin_n = 1'b0;
		i_pad_in[0] = 1'b0;
		step(2);
		chk_bit(o_pad_pull[0], 1'b1, "clock pull in reset");
		i_rst_pin_n = 1'b1;
		step(3);
		chk_bit(o_jtag_en, 1'b1, "test port on");
		chk_vec(64'(o_pad_pull[3:0]), 64'h7, "test pulls");
		chk_vec(64'(o_pad_oe[3:0]), 64'h8, "test drive");
		for (int v = 0; v < 2; v++) begin
			i_tdo = v[0];
			i_pad_in[2:0] = {3{v[0]}};
			step(1);
			chk_bit(o_pad_out[3], v[0], "data out");
			chk_bit(o_tms, v[0], "mode select");
			chk_bit(o_tck, v[0], "test clock");
			chk_bit(o_tdi, v[0], "data in");
		end
		// release with clock high: pins back to general use
		i_rst_pin_n = 1'b0;
		step(2);
		i_pad_in[0] = 1'b1;
		i_rst_pin_n = 1'b1;
		step(3);
		chk_bit(o_jtag_en, 1'b0, "test port off");
		chk_bit(o_tck, 1'b0, "clock gated");
		wr(1, 1, 1, 1, 1, pmx_pkg::PMX_FN_A);
		chk_bit(o_pad_oe[1] & o_pad_out[1], 1'b1, "line 1 as output");
		wr(0, 1, 1, 0, 1, pmx_pkg::PMX_FN_A);
		chk_bit(o_pad_oe[0], 1'b1, "line 0 as output");
		exp_pull = `PMX_PULL_RST | 51'h0_0000_0000_0002;
		exp_pull[40 + rnd % 10] = 1'b1;
		wr(40 + rnd % 10, 1, 0, 0, 1, pmx_pkg::PMX_FN_A);
		wr(63, 1, 0, 0, 1, pmx_pkg::PMX_FN_A);
		chk_vec(64'(o_pad_pull), 64'(exp_pull), "per-line pulls");
		// spike filter on a two-wire line
		i_pad_in[5] = 1'b1;
		step(1);
		chk_bit(o_line_in[5], 1'b0, "filter holds");
		for (int k = 0; k < 6 && o_line_in[5] !== 1'b1; k++) step(1);
		if (o_line_in[5] !== 1'b1) begin
			chk_bit(o_line_in[5], 1'b1, "filter timeout");
			close_out();
		end
		i_pad_in[5] = 1'b0;
		step(1);
		i_pad_in[5] = 1'b1;
		repeat (4) begin
			step(1);
			chk_bit(o_line_in[5], 1'b1, "spike ignored");
		end
		// analog interlock
		i_adc_req[16:14] = 3'b111;
		wr(14, 1, 1, 1, 0, pmx_pkg::PMX_FN_A);
		chk_vec(64'(o_adc_en[16:14]), 64'h6, "analog blocked");
		wr(14, 1, 1, 0, 0, pmx_pkg::PMX_FN_A);
		chk_vec(64'(o_adc_en[16:14]), 64'h7, "analog allowed");
		// usb pad pair
		wr(36, 0, 0, 0, 0, pmx_pkg::PMX_FN_A);
		wr(37, 0, 0, 0, 0, pmx_pkg::PMX_FN_A);
		chk_bit(o_usb_sel, 1'b1, "usb selected");
		wr(37, 1, 0, 0, 0, pmx_pkg::PMX_FN_A);
		chk_bit(o_usb_sel, 1'b0, "usb released");
		// each stop cause, then no restart; power-on reset rearms it
		for (int c = 0; c < 3; c++) begin
			if (c > 0) do_reset();
			force_bit(1'b1);
			chk_bit(o_slow_rc_clock_output_on, 1'b1, "force one ignored");
			rc = 1'b0;
			if (c == 0) force_bit(1'b0);
			if (c == 1) wr(20, 0, 0, 0, 0, pmx_pkg::PMX_FN_E);
			if (c == 2) wr(20, 1, 0, 0, 0, pmx_pkg::PMX_FN_F);
			chk_bit(o_slow_rc_clock_output_on, 1'b0, "clock stopped");
			wr(20, 0, 0, 0, 0, pmx_pkg::PMX_FN_F);
			force_bit(1'b1);
			chk_bit(o_slow_rc_clock_output_on, 1'b0, "clock stays off");
		end
		close_out();
	end
endmodule : pmx_pin_mux_tb
